// >>> logic/vic_top.sv
// Behaviour
// [R1] Thirty-two request inputs, each classed fast or vectored by software.
// [R2] Fast requests always beat vectored ones regardless of priority.
// [R3] Fast output is the OR of all active fast-class requests.
// [R4] Readable word shows which fast-class sources request now.
// [R5] Non-fast inputs are vectored with run-time programmable priority.
// [R6] Equal-priority vectored requests: lowest channel number wins.
// [R7] Normal output is the OR of all active vectored-class requests.
// [R8] Readable vector gives the winning vectored request's routine address.
// [R9] Each peripheral presents one combined interrupt line.
// [R10] GPIO edge pins (46) raise rising/falling/both, merged onto line 3.
// [R11] Reset: all vectored, priorities and vectors zero, outputs inactive.
`timescale 1ns/1ps
`default_nettype none
module vic_top
  import vic_pkg::*;
#(
  parameter int unsigned NCH = VIC_NUM_CH,
  parameter int unsigned PW = VIC_PRIO_W,
  parameter int unsigned AW = VIC_ADDR_W,
  parameter int unsigned NPIN = VIC_GPIO_PINS
) (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic [NCH-1:0] irq_lines,
  input wire logic [NPIN-1:0] gpio_pins,
  input wire logic [NPIN-1:0] gpio_rise_en,
  input wire logic [NPIN-1:0] gpio_fall_en,
  input wire logic [NPIN-1:0] gpio_edge_clr,
  input wire logic cfg_we,
  input wire logic [VIC_CH_W-1:0] cfg_ch,
  input wire logic cfg_fast,
  input wire logic [PW-1:0] cfg_prio,
  input wire logic [AW-1:0] cfg_vect,
  output logic fast_interrupt_request,
  output logic normal_irq,
  output logic [NCH-1:0] fast_status,
  output logic [NCH-1:0] vect_status,
  output logic [AW-1:0] vect_addr,
  output logic [VIC_CH_W-1:0] vect_ch,
  output logic [NCH-1:0] class_fast,
  output logic [NPIN-1:0] gpio_edge_pend
);
  // ------------------------------------------------------------
  // Per-channel configuration storage
  // ------------------------------------------------------------
  logic [NCH-1:0] fast_q, fast_d;
  logic [PW-1:0] prio_q [NCH];
  logic [PW-1:0] prio_d [NCH];
  logic [AW-1:0] vect_q [NCH];
  logic [AW-1:0] vect_d [NCH];

  always_comb begin
    fast_d = fast_q;
    for (int i = 0; i < NCH; i++) begin
      prio_d[i] = prio_q[i];
      vect_d[i] = vect_q[i];
    end
    if (cfg_we) begin
      fast_d[cfg_ch] = cfg_fast; // see [R1]
      prio_d[cfg_ch] = cfg_prio; // see [R5]
      vect_d[cfg_ch] = cfg_vect;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      fast_q <= VIC_RST_CLASS; // see [R11]
      for (int i = 0; i < NCH; i++) begin
        prio_q[i] <= VIC_RST_PRIO;
        vect_q[i] <= VIC_RST_VECT;
      end
    end else begin
      fast_q <= fast_d;
      for (int i = 0; i < NCH; i++) begin
        prio_q[i] <= prio_d[i];
        vect_q[i] <= vect_d[i];
      end
    end
  end

  // ------------------------------------------------------------
  // Input synchronisers and GPIO edge merge
  // ------------------------------------------------------------
  // Request lines come from other clock trees, so two flops each.
  // Costs two cycles of latency on every request edge.
  logic [NCH-1:0] rq1_q, rq2_q;
  logic [NCH-1:0] rq1_d, rq2_d;
  logic gpio_line;
  logic [NCH-1:0] req;

  always_comb begin
    rq1_d = irq_lines; // see [R9]
    rq2_d = rq1_q;
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      rq1_q <= '0;
      rq2_q <= '0;
    end else begin
      rq1_q <= rq1_d;
      rq2_q <= rq2_d;
    end
  end

  vic_gpio_edge #(
    .PINS(NPIN)
  ) u_edge (
    .core_clk(core_clk),
    .resetn(resetn),
    .pin_in(gpio_pins),
    .rise_en(gpio_rise_en),
    .fall_en(gpio_fall_en),
    .edge_clr(gpio_edge_clr),
    .edge_pend(gpio_edge_pend),
    .line_req(gpio_line)
  );

  // Pin edges share external line 3 with its own level request;
  // the handler must poll the pending word to tell them apart.
  for (genvar g = 0; g < NCH; g++) begin : g_req
    if (g == VIC_EXT_LINE3_CH) begin : g_merge
      assign req[g] = rq2_q[g] | gpio_line; // see [R10]
    end else begin : g_plain
      assign req[g] = rq2_q[g];
    end
  end

  // ------------------------------------------------------------
  // Classification and arbitration
  // ------------------------------------------------------------
  // Lower priority value is more urgent; scanning high to low with
  // <= lets the lowest channel win ties.
  logic [NCH-1:0] fstat_d, vstat_d;
  logic [PW-1:0] best_p;
  logic [VIC_CH_W-1:0] best_c;
  logic best_v;
  logic [AW-1:0] addr_d;

  always_comb begin
    fstat_d = req & fast_q; // see [R4]
    vstat_d = req & ~fast_q; // see [R5]
    best_p = '1;
    best_c = '0;
    best_v = 1'b0;
    for (int i = NCH - 1; i >= 0; i--) begin
      if (vstat_d[i] && (!best_v || prio_q[i] <= best_p)) begin // see [R6]
        best_p = prio_q[i];
        best_c = VIC_CH_W'(i);
        best_v = 1'b1;
      end
    end
    addr_d = best_v ? vect_q[best_c] : VIC_RST_VECT; // see [R8]
  end

  // ------------------------------------------------------------
  // Registered outputs
  // ------------------------------------------------------------
  // Winner is recomputed every cycle; a handler that reads the
  // vector late may see a newer, more urgent winner.
  logic fast_req_q, fast_req_d;
  logic irq_q, irq_d;
  logic [NCH-1:0] fstat_q, vstat_q;
  logic [AW-1:0] addr_q;
  logic [VIC_CH_W-1:0] ch_q, ch_d;

  always_comb begin
    fast_req_d = |fstat_d; // see [R3]
    // Fast class is kept off the normal line entirely
    irq_d = |vstat_d; // see [R7] see [R2]
    ch_d = best_c;
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      fast_req_q <= 1'b0; // see [R11]
      irq_q <= 1'b0;
      fstat_q <= '0;
      vstat_q <= '0;
      addr_q <= VIC_RST_VECT;
      ch_q <= '0;
    end else begin
      fast_req_q <= fast_req_d;
      irq_q <= irq_d;
      fstat_q <= fstat_d;
      vstat_q <= vstat_d;
      addr_q <= addr_d;
      ch_q <= ch_d;
    end
  end

  assign fast_interrupt_request = fast_req_q;
  assign normal_irq = irq_q;
  assign fast_status = fstat_q;
  assign vect_status = vstat_q;
  assign vect_addr = addr_q;
  assign vect_ch = ch_q;
  assign class_fast = fast_q;
endmodule
`default_nettype wire

// >>> logic/vic_pkg.sv
package vic_pkg;
  // ------------------------------------------------------------
  // Sizes
  // ------------------------------------------------------------
  localparam int unsigned VIC_NUM_CH = 32;
  localparam int unsigned VIC_PRIO_W = 4;
  localparam int unsigned VIC_ADDR_W = 32;
  localparam int unsigned VIC_GPIO_PINS = 46;
  localparam int unsigned VIC_EXT_LINE3_CH = 17;
  localparam int unsigned VIC_CH_W = 5;
  // ------------------------------------------------------------
  // Reset values
  // ------------------------------------------------------------
  localparam logic [31:0] VIC_RST_CLASS = 32'h0000_0000;
  localparam logic [3:0] VIC_RST_PRIO = 4'h0;
  localparam logic [31:0] VIC_RST_VECT = 32'h0000_0000;
  localparam logic [45:0] VIC_RST_EDGE = 46'h0;
  // ------------------------------------------------------------
  // Edge modes per pin
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    VIC_EDGE_OFF  = 2'b00,
    VIC_EDGE_RISE = 2'b01,
    VIC_EDGE_FALL = 2'b10,
    VIC_EDGE_BOTH = 2'b11
  } vic_edge_e;
endpackage

// >>> logic/vic_gpio_edge.sv
`timescale 1ns/1ps
`default_nettype none
module vic_gpio_edge
  import vic_pkg::*;
#(
  parameter int unsigned PINS = VIC_GPIO_PINS
) (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic [PINS-1:0] pin_in,
  input wire logic [PINS-1:0] rise_en,
  input wire logic [PINS-1:0] fall_en,
  input wire logic [PINS-1:0] edge_clr,
  output logic [PINS-1:0] edge_pend,
  output logic line_req
);
  // ------------------------------------------------------------
  // Two-stage synchroniser, then edge capture
  // ------------------------------------------------------------
  logic [PINS-1:0] s1_q, s2_q, s3_q, pend_q;
  logic [PINS-1:0] s1_d, s2_d, s3_d, pend_d;
  logic line_q, line_d;
  logic [2:0] arm_q, arm_d;

  always_comb begin
    s1_d = pin_in;
    s2_d = s1_q;
    s3_d = s2_q;
    // Chain resets to zero, not to the pin level: ignore edges until
    // all three stages hold real samples, else a high pin fakes a rise
    arm_d = {arm_q[1:0], 1'b1};
    for (int i = 0; i < PINS; i++) begin
      // Set wins over a clear in the same cycle
      pend_d[i] = (pend_q[i] & ~edge_clr[i])
                | (arm_q[2] & rise_en[i] & s2_q[i] & ~s3_q[i])
                | (arm_q[2] & fall_en[i] & ~s2_q[i] & s3_q[i]); // see [R10]
    end
    line_d = |pend_d; // see [R10]
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
      pend_q <= '0;
      line_q <= 1'b0;
      arm_q <= '0;
    end else begin
      arm_q <= arm_d;
      s1_q <= s1_d;
      s2_q <= s2_d;
      s3_q <= s3_d;
      pend_q <= pend_d;
      line_q <= line_d;
    end
  end

  assign edge_pend = pend_q;
  assign line_req = line_q;
endmodule
`default_nettype wire

// >>> sim/vic_properties.sv
`timescale 1ns/1ps
`default_nettype none
module vic_properties
  import vic_pkg::*;
#(parameter int unsigned NCH = 32, AW = 32, NPIN = 46) (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic [NCH-1:0] irq_lines,
  input wire logic cfg_we,
  input wire logic [VIC_CH_W-1:0] cfg_ch,
  input wire logic cfg_fast,
  input wire logic fast_interrupt_request,
  input wire logic normal_irq,
  input wire logic [NCH-1:0] fast_status,
  input wire logic [NCH-1:0] vect_status,
  input wire logic [AW-1:0] vect_addr,
  input wire logic [VIC_CH_W-1:0] vect_ch,
  input wire logic [NCH-1:0] class_fast,
  input wire logic [NPIN-1:0] gpio_edge_pend
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!resetn);
  // ----
  // Checks
  // ----
  fast_or_a: assert property (fast_interrupt_request == |fast_status)
    else $error("fast output differs from status OR");
  norm_or_a: assert property (normal_irq == |vect_status)
    else $error("normal output differs from status OR");
  class_split_a: assert property ((fast_status & vect_status) == '0)
    else $error("source in both classes");
  no_vect_a: assert property (!normal_irq |-> vect_addr == '0 && vect_ch == '0)
    else $error("vector shown with nothing pending");
  win_chan_a: assert property (normal_irq |-> vect_status[vect_ch])
    else $error("winning channel not pending");
  rst_out_a: assert property (disable iff (1'b0) !resetn |=>
    !fast_interrupt_request && !normal_irq && class_fast == '0) else $error("reset state wrong");
  cfg_class_a: assert property (cfg_we |=> ##1
    class_fast[$past(cfg_ch, 2)] == $past(cfg_fast, 2)) else $error("class not written");
  idle_out_a: assert property ((irq_lines == '0 && gpio_edge_pend == '0)[*6] |=>
    !normal_irq && !fast_interrupt_request) else $error("output without request");
  edge_req_a: assert property (gpio_edge_pend != '0 |-> ##[1:6]
    (normal_irq || fast_interrupt_request)) else $error("edge not signalled");
  cover property (fast_interrupt_request && normal_irq);
  cover property (normal_irq && vect_ch == 5'h11);
  cover property ($fell(normal_irq));
endmodule
bind vic_top vic_properties #(.NCH(NCH), .AW(AW), .NPIN(NPIN)) i_props (.*);
`default_nettype wire

// >>> sim/vic_periph.sv
`timescale 1ns/1ps
`default_nettype none
module vic_periph (
  input wire logic core_clk,
  input wire logic [31:0] periph_req,
  output logic [31:0] irq_lines
);
  // Flags already merged, one level per peripheral
  always @(negedge core_clk) irq_lines <= periph_req;
endmodule
`default_nettype wire

// >>> sim/test_vectored_interrupt_controller.sv
`timescale 1ns/1ps
`default_nettype none
module test_vectored_interrupt_controller;
  import vic_pkg::*;
`define CHK(n, e, s) begin checks_done++; if ((s) !== (e)) begin n_errors++; \
  $display("ERROR %s exp %0h got %0h", n, e, s); end end
  logic core_clk = 0, resetn = 0, cfg_we = 0, cfg_fast = 0;
  logic [31:0] periph_req = '0, cfg_vect = '0;
  logic [3:0] cfg_prio = '0;
  logic [4:0] cfg_ch = '0;
  logic [45:0] gpio_pins = 46'h2000_0000_0000, gpio_rise_en = '0, gpio_fall_en = '0;
  logic [45:0] gpio_edge_clr = '0;
  wire logic fast_interrupt_request, normal_irq;
  wire logic [31:0] irq_lines, fast_status, vect_status, vect_addr, class_fast;
  wire logic [4:0] vect_ch;
  wire logic [45:0] gpio_edge_pend;
  int n_errors = 0, checks_done = 0;
  vic_periph i_periph (.*);
  vic_top i_dut (.*);
  initial forever #5 core_clk = ~core_clk;
  // ----
  // Tasks
  // ----
  task automatic wt(input int n);
    repeat (n) @(negedge core_clk);
  endtask
  task automatic cfg(input logic [4:0] c, input logic f, input logic [3:0] p,
                     input logic [31:0] v);
    @(negedge core_clk);
    cfg_we = 1; cfg_ch = c; cfg_fast = f; cfg_prio = p; cfg_vect = v;
    @(negedge core_clk);
    cfg_we = 0;
  endtask
  task automatic conclude;
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // Pin edge must latch within a bounded wait, else stop
  task automatic pend_wait(input int i);
    for (int k = 0; k < 10 && gpio_edge_pend[i] !== 1'b1; k++) wt(1);
    `CHK("pend", 1'b1, gpio_edge_pend[i])
    if (gpio_edge_pend[i] !== 1'b1) conclude;
    wt(6);
  endtask
  // ----
  // Sequence
  // ----
  initial begin
    wt(5);
    `CHK("class", 32'h0, class_fast)
    resetn = 1;
    cfg(3, 0, 2, 32'h300); cfg(5, 0, 2, 32'h500); cfg(9, 0, 1, 32'h900);
    cfg(7, 1, 0, 0); cfg(8, 1, 0, 0); cfg(17, 0, 0, 32'h1700);
    wt(2);
    `CHK("class", 32'h180, class_fast)
    periph_req = 32'h28; wt(4);
    `CHK("vch", 5'h3, vect_ch)
    `CHK("va", 32'h300, vect_addr)
    `CHK("vst", 32'h28, vect_status)
    periph_req = 32'h228; wt(4);
    `CHK("vch", 5'h9, vect_ch)
    cfg(9, 0, 3, 32'h900); wt(2);
    `CHK("vch", 5'h3, vect_ch)
    periph_req = 32'h1a8; wt(4);
    `CHK("vch", 5'h3, vect_ch)
    `CHK("fst", 32'h180, fast_status)
    `CHK("fiq", 1'b1, fast_interrupt_request)
    `CHK("nirq", 1'b1, normal_irq)
    periph_req = 32'h180; wt(4);
    `CHK("nirq", 1'b0, normal_irq)
    `CHK("va", 32'h0, vect_addr)
    periph_req = '0; gpio_rise_en[0] = 1; gpio_fall_en[45] = 1; wt(4);
    gpio_pins[0] = 1; pend_wait(0);
    `CHK("vch", 5'h11, vect_ch)
    gpio_edge_clr[0] = 1; gpio_pins[45] = 0; wt(1);
    gpio_edge_clr[0] = 0; pend_wait(45);
    `CHK("pend", 46'h2000_0000_0000, gpio_edge_pend)
    // Both edges enabled on one pin: the rise must latch too
    gpio_edge_clr[45] = 1; gpio_rise_en[45] = 1; gpio_pins[45] = 1; wt(1);
    gpio_edge_clr[45] = 0; wt(1);
    `CHK("pclr", 1'b0, gpio_edge_pend[45])
    pend_wait(45);
    resetn = 0; wt(2);
    `CHK("class", 32'h0, class_fast)
    `CHK("nirq", 1'b0, normal_irq)
    resetn = 1; wt(1);
    conclude;
  end
endmodule
`default_nettype wire
